/* psr_defs.svh */
// Purpose: constants of the privileged shadow and scratch register block
// Assumes: included by bare name; wishbone byte offsets, 32-bit data
// Notes: register layout below is the software view of this block
// How it works
// RULE1: in firmware mode with shadow enable set, R8-R14 and R25 use shadow registers
// RULE2: firmware never writes a shadow register in a flow's last two cycles
// RULE3: twenty-four scratch registers reached only by internal-register moves
// RULE4: scratch read data reaches dependents one cycle after the read
// RULE5: cache config stores changing other bits need barriers, no concurrent fetches
// RULE6: board-cache select-only stores need a barrier before and after
// RULE7: reading l2 error status unlocks l2 status and address
// RULE8: reading ext error status unlocks status, address, syndrome and tag address
// RULE9: no locked loads, conditional stores or undefined-address stores to cache registers
// RULE10: no conditional store to cacheable space while forced hit is on
// RULE11: after clearing l2 forced hit: barrier, l2 status read, barrier, then stores
// RULE12: after clearing board forced hit: barrier, ext status read, barrier, then stores
// RULE13: cache register loads only while allocate-cycle bit 01 is clear
// RULE14: after firmware call no return in cycle 0, no exception-address read in 0,1
// RULE15: after a shadow write no firmware return in cycles 0 or 1
// RULE16: locked privileged physical load goes to pipe zero, alone in memory unit
// RULE17: no memory-unit register move with a load; some reads barred cycles 1,2
// RULE18: after a store no parity status or miss-file mode read in cycles 1,2
// RULE19: no invalidate-single write in the cycle after a virtual memory op
// RULE20: memory trap keeps cycle 0,1 fetch-unit and invalidate writes; exception address correct
// RULE21: fetch-unit traps except exempt kinds keep invalidate-single writes in cycles 0,1
// RULE22: at most one stalling firmware return per aligned group of four
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH
`define PSR_OFF_CTRL 8'h00
`define PSR_OFF_L2_STAT 8'h04
`define PSR_OFF_L2_ADDR 8'h08
`define PSR_OFF_EXT_STAT 8'h0C
`define PSR_OFF_EXT_ADDR 8'h10
`define PSR_OFF_FILL_SYNDROME 8'h14
`define PSR_OFF_TAG_ADDR 8'h18
`define PSR_OFF_EXCEPTION_ADDRESS 8'h1C
`define PSR_OFF_STATUS 8'h20
`define PSR_CTRL_SDE_BIT 0
`define PSR_CTRL_RST 1'b1
`define PSR_ST_L2_LOCK_BIT 0
`define PSR_ST_EXT_LOCK_BIT 1
`define PSR_ST_FILL_LOCK_BIT 2
`define PSR_ST_WIN_BIT 3
`define PSR_SCR_DEPTH 24
`define PSR_SHD_LO 5'h08
`define PSR_SHD_HI 5'h0E
`define PSR_SHD_EXTRA 5'h19
`define PSR_SHD_BASE 6'h20
`define PSR_SHD_EXTRA_IDX 6'h27
`define PSR_RF_ENTRIES 40
`endif

/* psr_pkg.sv */
// Purpose: shared types of the privileged shadow and scratch register block
// Assumes: nothing
// Notes: trap kinds decide which writes survive a trap
package psr_pkg;
    // trap window: idle, or cycle 1 after a trap
    typedef enum logic [1:0] {PSR_TW_IDLE = 2'b00, PSR_TW_C1 = 2'b01} psr_trap_win_e;
    // memory unit or barrier, fetch unit, fetch unit exempt kind
    typedef enum logic [1:0] {PSR_TRAP_MBOX = 2'b00, PSR_TRAP_IBOX = 2'b01,
        PSR_TRAP_IBOX_EXEMPT = 2'b10} psr_trap_src_e;
endpackage

/* psr_scratch.sv */
// Purpose: bank of privileged scratch registers
// Assumes: written and read only by internal-register moves
// Notes: indices past the bank are ignored on write and read as zero
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_scratch import psr_pkg::*; #(
    parameter int DATA_W = 64,
    parameter int DEPTH = `PSR_SCR_DEPTH
) (
    input wire logic ref_clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic wr_en_i, // committed move-to
    input wire logic [4:0] wr_idx_i, // scratch index
    input wire logic [DATA_W-1:0] wr_data_i, // write data
    input wire logic [4:0] rd_idx_i, // scratch index to read
    output logic [DATA_W-1:0] rd_data_o // read data, combinational
);
    logic [DATA_W-1:0] bank [0:DEPTH-1];

    // out-of-range moves do nothing rather than alias
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i && 32'(wr_idx_i) < DEPTH)
            bank[wr_idx_i] <= wr_data_i; // [RULE3]
    end

    assign rd_data_o = (32'(rd_idx_i) < DEPTH) ? bank[rd_idx_i] : '0;

    // an in-range move-to is readable from the next cycle on
    property p_scr_write_lands;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_en_i && 32'(wr_idx_i) < DEPTH |=> bank[$past(wr_idx_i)] == $past(wr_data_i);
    endproperty
    a_scr_write_lands: assert property (p_scr_write_lands) // [RULE3]
        else $error("scratch write did not land");
endmodule // psr_scratch

/* psr_shadow_rf.sv */
// Purpose: integer register file with eight overlaid shadow registers
// Assumes: one write and one read port, combinational read
// Notes: shadow entries sit at indices 32..39 of one array
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_shadow_rf import psr_pkg::*; #(
    parameter int DATA_W = 64
) (
    input wire logic ref_clk_i, // core clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic steer_i, // firmware mode and shadow enable
    input wire logic wr_en_i, // write strobe
    input wire logic [4:0] wr_addr_i, // write register number
    input wire logic [DATA_W-1:0] wr_data_i, // write data
    input wire logic [4:0] rd_addr_i, // read register number
    output logic [DATA_W-1:0] rd_data_o // read data
);
    logic [DATA_W-1:0] mem [0:`PSR_RF_ENTRIES-1];

    // map a register number to its array entry
    function automatic logic [5:0] psr_map(input logic [4:0] a, input logic sh);
        logic [5:0] idx;
        idx = {1'b0, a};
        if (sh && a >= `PSR_SHD_LO && a <= `PSR_SHD_HI)
            idx = `PSR_SHD_BASE + {1'b0, 5'(a - `PSR_SHD_LO)}; // [RULE1]
        else if (sh && a == `PSR_SHD_EXTRA)
            idx = `PSR_SHD_EXTRA_IDX; // [RULE1]
        return idx;
    endfunction

    // data array has no reset: contents are software's
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
            mem[psr_map(wr_addr_i, steer_i)] <= wr_data_i;
    end

    assign rd_data_o = mem[psr_map(rd_addr_i, steer_i)];

    // the base copy of the extra register must not move while it is overlaid
    property p_shadow_hides_base;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_en_i && steer_i && wr_addr_i == `PSR_SHD_EXTRA |=> $stable(mem[25]);
    endproperty
    a_shadow_hides_base: assert property (p_shadow_hides_base) // [RULE1]
        else $error("shadowed write reached the base register");
endmodule // psr_shadow_rf

/* psr_top.sv */
// Purpose: shadow registers, scratch bank, error locks and trap write survival
// Assumes: core strobes are synchronous one-cycle pulses on ref_clk_i
// Notes: wishbone reads of error status registers unlock their groups
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_top import psr_pkg::*; #(
    parameter int DATA_W = 64,
    parameter int ADDR_W = 32
) (
    input wire logic ref_clk_i, // core clock, 250 MHz
    input wire logic rst_b_i, // async reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic fw_mode_i, // privileged firmware mode
    input wire logic rf_wr_en_i, // integer register write
    input wire logic [4:0] rf_wr_addr_i, // register number
    input wire logic [DATA_W-1:0] rf_wr_data_i, // write data
    input wire logic [4:0] rf_rd_addr_i, // register number
    output logic [DATA_W-1:0] rf_rd_data_o, // read data, next cycle
    input wire logic mtpr_scr_i, // move to scratch register
    input wire logic [4:0] mtpr_idx_i, // scratch index
    input wire logic [DATA_W-1:0] mtpr_data_i, // move-to data
    input wire logic mfpr_scr_i, // move from scratch register
    input wire logic [4:0] mfpr_idx_i, // scratch index
    output logic [DATA_W-1:0] mfpr_data_o, // move-from data
    output logic mfpr_valid_o, // move-from data valid
    input wire logic dxis_i, // invalidate-single write
    input wire logic [ADDR_W-1:0] dxis_addr_i, // address to invalidate
    output logic dxis_o, // committed invalidate pulse
    output logic [ADDR_W-1:0] dxis_addr_o, // committed address
    input wire logic trap_i, // trap taken, cycle 0
    input wire psr_trap_src_e trap_src_i, // kind of trap
    input wire logic [ADDR_W-1:0] trap_pc_i, // faulting program counter
    output logic [ADDR_W-1:0] exception_address_o, // exception address
    input wire logic l2_err_i, // l2 error event
    input wire logic [31:0] l2_err_stat_i, // l2 error status
    input wire logic [ADDR_W-1:0] l2_err_addr_i, // l2 error address
    input wire logic ext_err_i, // external interface error event
    input wire logic [31:0] ext_err_stat_i, // ext error status
    input wire logic [ADDR_W-1:0] ext_err_addr_i, // ext error address
    input wire logic [ADDR_W-1:0] board_cache_tag_address_i, // board cache tag address
    input wire logic fill_err_i, // fill error event
    input wire logic fill_uncorr_i, // fill error not correctable
    input wire logic [15:0] fill_syndrome_i // fill syndrome
);
    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic sde_r, sde_nxt;
    logic req, rd_take;
    logic [31:0] rd_mux;
    logic [31:0] status_w;
    logic l2_lock_r, l2_lock_nxt, ext_lock_r, ext_lock_nxt, fill_lock_r, fill_lock_nxt;
    logic [31:0] l2_stat_r, l2_stat_nxt, ext_stat_r, ext_stat_nxt;
    logic [ADDR_W-1:0] l2_addr_r, l2_addr_nxt, ext_addr_r, ext_addr_nxt;
    logic [ADDR_W-1:0] tag_r, tag_nxt;
    logic [15:0] syn_r, syn_nxt;
    psr_trap_win_e win_r, win_nxt;
    psr_trap_src_e src_r, src_nxt;
    logic [ADDR_W-1:0] exc_r, exc_nxt;
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign rd_take = req && !wb_we_i;
    assign status_w = {28'h0000000, win_r == PSR_TW_C1, fill_lock_r, ext_lock_r, l2_lock_r};
    // read mux; unmapped offsets answer with zero
    always_comb
    begin
        case (wb_adr_i)
            `PSR_OFF_CTRL: rd_mux = {31'h00000000, sde_r};
            `PSR_OFF_L2_STAT: rd_mux = l2_stat_r;
            `PSR_OFF_L2_ADDR: rd_mux = l2_addr_r[31:0];
            `PSR_OFF_EXT_STAT: rd_mux = ext_stat_r;
            `PSR_OFF_EXT_ADDR: rd_mux = ext_addr_r[31:0];
            `PSR_OFF_FILL_SYNDROME: rd_mux = {16'h0000, syn_r};
            `PSR_OFF_TAG_ADDR: rd_mux = tag_r[31:0];
            `PSR_OFF_EXCEPTION_ADDRESS: rd_mux = exc_r[31:0];
            `PSR_OFF_STATUS: rd_mux = status_w;
            default: rd_mux = 32'h00000000;
        endcase
    end
    // ack one cycle after the request, dropped the cycle after
    always_comb
    begin
        ack_nxt = req;
        dat_nxt = rd_take ? rd_mux : dat_r;
        sde_nxt = sde_r;
        if (req && wb_we_i && wb_adr_i == `PSR_OFF_CTRL && wb_sel_i[0])
            sde_nxt = wb_dat_i[`PSR_CTRL_SDE_BIT];
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            sde_r <= `PSR_CTRL_RST; // shadowing is the normal state
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            sde_r <= sde_nxt;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    ////////////////////////////////////////////////////////////////////////////
    // error capture and unlock-on-read
    // a new error in the unlocking cycle is captured and relocks, except a correctable fill error: set wins
    always_comb
    begin
        l2_lock_nxt = l2_lock_r;
        l2_stat_nxt = l2_stat_r;
        l2_addr_nxt = l2_addr_r;
        ext_lock_nxt = ext_lock_r;
        ext_stat_nxt = ext_stat_r;
        ext_addr_nxt = ext_addr_r;
        tag_nxt = tag_r;
        fill_lock_nxt = fill_lock_r;
        syn_nxt = syn_r;
        if (rd_take && wb_adr_i == `PSR_OFF_L2_STAT)
            l2_lock_nxt = 1'b0; // [RULE7]
        if (rd_take && wb_adr_i == `PSR_OFF_EXT_STAT)
        begin
            ext_lock_nxt = 1'b0; // [RULE8]
            fill_lock_nxt = 1'b0; // [RULE8]
        end
        if (l2_err_i && !l2_lock_nxt)
        begin
            l2_stat_nxt = l2_err_stat_i;
            l2_addr_nxt = l2_err_addr_i;
            l2_lock_nxt = 1'b1;
        end
        if (ext_err_i && !ext_lock_nxt)
        begin
            ext_stat_nxt = ext_err_stat_i;
            ext_addr_nxt = ext_err_addr_i;
            tag_nxt = board_cache_tag_address_i;
            ext_lock_nxt = 1'b1;
        end
        // correctable errors load without locking; uncorrectable ones lock
        if (fill_err_i && !fill_lock_nxt)
        begin
            syn_nxt = fill_syndrome_i;
            fill_lock_nxt = fill_uncorr_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            l2_lock_r <= 1'b0;
            l2_stat_r <= 32'h00000000;
            l2_addr_r <= '0;
            ext_lock_r <= 1'b0;
            ext_stat_r <= 32'h00000000;
            ext_addr_r <= '0;
            tag_r <= '0;
            fill_lock_r <= 1'b0;
            syn_r <= 16'h0000;
        end
        else
        begin
            l2_lock_r <= l2_lock_nxt;
            l2_stat_r <= l2_stat_nxt;
            l2_addr_r <= l2_addr_nxt;
            ext_lock_r <= ext_lock_nxt;
            ext_stat_r <= ext_stat_nxt;
            ext_addr_r <= ext_addr_nxt;
            tag_r <= tag_nxt;
            fill_lock_r <= fill_lock_nxt;
            syn_r <= syn_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trap window: which writes in cycles 0 and 1 survive
    logic in_win, scr_commit, dxis_commit;
    psr_trap_src_e cur_src;
    assign in_win = trap_i || win_r == PSR_TW_C1;
    assign cur_src = trap_i ? trap_src_i : src_r;
    // fetch-unit register writes survive only a memory-unit trap
    assign scr_commit = mtpr_scr_i && (!in_win || cur_src == PSR_TRAP_MBOX); // [RULE20]
    // invalidate-single survives every trap but the exempt fetch kinds
    assign dxis_commit = dxis_i && (!in_win || cur_src != PSR_TRAP_IBOX_EXEMPT); // [RULE21]

    always_comb
    begin
        win_nxt = win_r;
        src_nxt = src_r;
        exc_nxt = exc_r;
        case (win_r)
            PSR_TW_IDLE: win_nxt = trap_i ? PSR_TW_C1 : PSR_TW_IDLE;
            PSR_TW_C1: win_nxt = trap_i ? PSR_TW_C1 : PSR_TW_IDLE;
            default: win_nxt = PSR_TW_IDLE;
        endcase
        if (trap_i)
        begin
            src_nxt = trap_src_i;
            exc_nxt = trap_pc_i; // surviving writes never disturb this [RULE20]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            win_r <= PSR_TW_IDLE;
            src_r <= PSR_TRAP_MBOX;
            exc_r <= '0;
        end
        else
        begin
            win_r <= win_nxt;
            src_r <= src_nxt;
            exc_r <= exc_nxt;
        end
    end
    assign exception_address_o = exc_r;
    ////////////////////////////////////////////////////////////////////////////
    // register file, scratch bank and registered core outputs
    logic [DATA_W-1:0] rf_rd_w, scr_rd_w;
    logic [DATA_W-1:0] rf_q_r, rf_q_nxt, mf_q_r, mf_q_nxt;
    logic mf_v_r, mf_v_nxt, dx_r, dx_nxt;
    logic [ADDR_W-1:0] dxa_r, dxa_nxt;
    psr_shadow_rf #(.DATA_W(DATA_W)) u_rf (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .steer_i(fw_mode_i && sde_r), // [RULE1]
        .wr_en_i(rf_wr_en_i),
        .wr_addr_i(rf_wr_addr_i),
        .wr_data_i(rf_wr_data_i),
        .rd_addr_i(rf_rd_addr_i),
        .rd_data_o(rf_rd_w)
    );

    psr_scratch #(.DATA_W(DATA_W), .DEPTH(`PSR_SCR_DEPTH)) u_scr (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(scr_commit), // [RULE3]
        .wr_idx_i(mtpr_idx_i),
        .wr_data_i(mtpr_data_i),
        .rd_idx_i(mfpr_idx_i),
        .rd_data_o(scr_rd_w)
    );

    // one register stage: scratch data is usable the cycle after the move
    always_comb
    begin
        rf_q_nxt = rf_rd_w;
        mf_v_nxt = mfpr_scr_i; // [RULE4]
        mf_q_nxt = mfpr_scr_i ? scr_rd_w : mf_q_r; // [RULE4]
        dx_nxt = dxis_commit;
        dxa_nxt = dxis_commit ? dxis_addr_i : dxa_r;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rf_q_r <= '0;
            mf_q_r <= '0;
            mf_v_r <= 1'b0;
            dx_r <= 1'b0;
            dxa_r <= '0;
        end
        else
        begin
            rf_q_r <= rf_q_nxt;
            mf_q_r <= mf_q_nxt;
            mf_v_r <= mf_v_nxt;
            dx_r <= dx_nxt;
            dxa_r <= dxa_nxt;
        end
    end
    assign rf_rd_data_o = rf_q_r;
    assign mfpr_data_o = mf_q_r;
    assign mfpr_valid_o = mf_v_r;
    assign dxis_o = dx_r;
    assign dxis_addr_o = dxa_r;
    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_mbox_trap_write;
        trap_i && trap_src_i == PSR_TRAP_MBOX && mtpr_scr_i && mtpr_idx_i < 5'h18;
    endsequence
    sequence s_ibox_trap_then_dxis;
        trap_i && trap_src_i == PSR_TRAP_IBOX ##1 dxis_i && !trap_i;
    endsequence
    property p_scr_latency;
        mfpr_scr_i |=> mfpr_valid_o && mfpr_data_o == $past(scr_rd_w);
    endproperty
    a_scr_latency: assert property (p_scr_latency) // [RULE4]
        else $error("scratch read not valid one cycle later");
    property p_l2_unlock;
        rd_take && wb_adr_i == `PSR_OFF_L2_STAT && !l2_err_i |=> !l2_lock_r ##1 !wb_ack_o;
    endproperty
    a_l2_unlock: assert property (p_l2_unlock) // [RULE7]
        else $error("l2 status read left the lock set");
    property p_ext_unlock;
        rd_take && wb_adr_i == `PSR_OFF_EXT_STAT && !ext_err_i && !fill_err_i
            |=> !ext_lock_r && !fill_lock_r && wb_ack_o;
    endproperty
    a_ext_unlock: assert property (p_ext_unlock) // [RULE8]
        else $error("ext status read left a lock set");
    property p_mbox_trap_keeps;
        s_mbox_trap_write |=> u_scr.bank[$past(mtpr_idx_i)] == $past(mtpr_data_i)
            && exception_address_o == $past(trap_pc_i);
    endproperty
    a_mbox_trap_keeps: assert property (p_mbox_trap_keeps) // [RULE20]
        else $error("memory trap lost a write or the faulting pc");
    property p_ibox_dxis;
        s_ibox_trap_then_dxis |=> dxis_o && dxis_addr_o == $past(dxis_addr_i);
    endproperty
    a_ibox_dxis: assert property (p_ibox_dxis) // [RULE21]
        else $error("invalidate aborted by a fetch-unit trap");
    // outputs of window cycles 0 and 1 show up one cycle later, at cycles 1 and 2
    property p_exempt_aborts;
        trap_i && trap_src_i == PSR_TRAP_IBOX_EXEMPT ##1 !trap_i |-> !dxis_o [*2];
    endproperty
    a_exempt_aborts: assert property (p_exempt_aborts) // [RULE21]
        else $error("exempt trap let an invalidate through");
    property p_shadow_steer;
        rf_wr_en_i && fw_mode_i && sde_r && rf_wr_addr_i == `PSR_SHD_LO
            |=> u_rf.mem[`PSR_SHD_BASE] == $past(rf_wr_data_i);
    endproperty
    a_shadow_steer: assert property (p_shadow_steer) // [RULE1]
        else $error("shadowed write missed its shadow register");
endmodule // psr_top

/* test_psr_top.sv */
// Purpose: self-checking bench of the privileged shadow and scratch register block
// Assumes: inputs change on the rising edge, outputs are sampled on the falling edge, except wishbone replies, read at the rising edge
// Notes: the design carries its own assertions, so no checker is bound here
`timescale 1ns/1ps
`include "psr_defs.svh"
module test_psr_top import psr_pkg::*; ();
logic ref_clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fw_mode_i, rf_wr_en_i;
logic [7:0] wb_adr_i;
logic [3:0] wb_sel_i;
logic [31:0] wb_dat_i, wb_dat_o, trap_pc_i, exception_address_o, dxis_addr_i, dxis_addr_o;
logic [31:0] l2_err_stat_i, l2_err_addr_i, ext_err_stat_i, ext_err_addr_i, board_cache_tag_address_i;
logic [4:0] rf_wr_addr_i, rf_rd_addr_i, mtpr_idx_i, mfpr_idx_i;
logic [63:0] rf_wr_data_i, rf_rd_data_o, mtpr_data_i, mfpr_data_o;
logic mtpr_scr_i, mfpr_scr_i, mfpr_valid_o, dxis_i, dxis_o, trap_i;
logic l2_err_i, ext_err_i, fill_err_i, fill_uncorr_i;
logic [15:0] fill_syndrome_i;
psr_trap_src_e trap_src_i;
int mismatches = 0;
int comparisons = 0;
psr_top psr_top_inst (.*);
////////////////////////////////////////////////////////////////////////////////
// free-running core clock, 4 ns period
always #2 ref_clk_i = ~ref_clk_i;
task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
        mismatches++;
        $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
// classic single cycle; ack is read before the edge's own updates land
task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] w,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= w;
    do
    begin
        @(posedge ref_clk_i);
        n++;
    end
    while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(64'(n), 64'h2); // ack stands at the second edge after the request
endtask
task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, a, 32'h0, d);
    chk(64'(d), 64'(exp));
endtask
// core-side strobes are single-cycle pulses
task automatic rfw(input logic fw, input logic [4:0] a, input logic [63:0] d);
    @(posedge ref_clk_i);
    fw_mode_i <= fw;
    rf_wr_en_i <= 1'b1;
    rf_wr_addr_i <= a;
    rf_wr_data_i <= d;
    @(posedge ref_clk_i);
    rf_wr_en_i <= 1'b0;
endtask
task automatic rfr(input logic fw, input logic [4:0] a, input logic [63:0] exp);
    @(posedge ref_clk_i);
    fw_mode_i <= fw;
    rf_rd_addr_i <= a;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(rf_rd_data_o, exp);
endtask
task automatic mtw(input logic [4:0] i, input logic [63:0] d);
    @(posedge ref_clk_i);
    mtpr_scr_i <= 1'b1;
    mtpr_idx_i <= i;
    mtpr_data_i <= d;
    @(posedge ref_clk_i);
    mtpr_scr_i <= 1'b0;
endtask
task automatic mfr(input logic [4:0] i, input logic [63:0] exp);
    @(posedge ref_clk_i);
    mfpr_scr_i <= 1'b1;
    mfpr_idx_i <= i;
    @(posedge ref_clk_i);
    mfpr_scr_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(64'(mfpr_valid_o), 64'h1);
    chk(mfpr_data_o, exp);
    @(negedge ref_clk_i);
    chk(64'(mfpr_valid_o), 64'h0);
endtask
////////////////////////////////////////////////////////////////////////////////
// shadow overlay: steered registers keep two values, others only one
task automatic t_shadow();
    logic [4:0] r;
    logic [31:0] d;
    rdchk(`PSR_OFF_CTRL, 32'h1);
    rdchk(8'h24, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
        r = (i < 7) ? 5'(8 + i) : ((i == 7) ? 5'h19 : 5'h0F);
        rfw(1'b1, r, {32'h5A5A0000, 27'h0, r});
        rfw(1'b0, r, {32'h0000A5A5, 27'h0, r});
        rfr(1'b1, r, {(i < 8) ? 32'h5A5A0000 : 32'h0000A5A5, 27'h0, r});
        rfr(1'b0, r, {32'h0000A5A5, 27'h0, r});
    end
    wb(1'b1, `PSR_OFF_CTRL, 32'h0, d);
    rdchk(`PSR_OFF_CTRL, 32'h0);
    rfr(1'b1, 5'h08, {32'h0000A5A5, 27'h0, 5'h08});
    wb(1'b1, `PSR_OFF_CTRL, 32'h1, d);
    $display("test shadow done");
endtask
// scratch bank: both ends of the index range, one past the end ignored
task automatic t_scratch();
    mtw(5'd0, 64'h0123456789ABCDEF);
    mtw(5'd23, 64'hFEDCBA9876543210);
    mtw(5'd24, 64'h00000000DEADBEEF);
    mfr(5'd0, 64'h0123456789ABCDEF);
    mfr(5'd23, 64'hFEDCBA9876543210);
    mfr(5'd24, 64'h0);
    $display("test scratch done");
endtask
// back-to-back error events: only the first is kept until the status read
task automatic t_errors();
    // plain loads, no barrier-bound or conditional stores
    // forced hit never set; allocate-cycle stays clear
    @(posedge ref_clk_i);
    {l2_err_i, ext_err_i, fill_err_i, fill_uncorr_i} <= 4'hF;
    {l2_err_stat_i, l2_err_addr_i, ext_err_stat_i} <= {32'hA5, 32'h1234, 32'hC3};
    {ext_err_addr_i, board_cache_tag_address_i, fill_syndrome_i} <= {32'h5678, 32'h9ABC, 16'hBEEF};
    @(posedge ref_clk_i);
    {l2_err_stat_i, l2_err_addr_i, ext_err_stat_i} <= {32'h5A, 32'h4321, 32'h3C};
    {ext_err_addr_i, board_cache_tag_address_i, fill_syndrome_i} <= {32'h8765, 32'hCBA9, 16'hFEED};
    @(posedge ref_clk_i);
    {l2_err_i, ext_err_i, fill_err_i, fill_uncorr_i} <= 4'h0;
    rdchk(`PSR_OFF_STATUS, 32'h7);
    rdchk(`PSR_OFF_L2_ADDR, 32'h1234);
    rdchk(`PSR_OFF_L2_STAT, 32'hA5);
    rdchk(`PSR_OFF_STATUS, 32'h6);
    rdchk(`PSR_OFF_EXT_ADDR, 32'h5678);
    rdchk(`PSR_OFF_TAG_ADDR, 32'h9ABC);
    rdchk(`PSR_OFF_FILL_SYNDROME, 32'hBEEF);
    rdchk(`PSR_OFF_EXT_STAT, 32'hC3);
    rdchk(`PSR_OFF_STATUS, 32'h0);
    // a correctable fill error loads the syndrome without locking it
    @(posedge ref_clk_i);
    {fill_err_i, fill_syndrome_i} <= {1'b1, 16'h0F0F};
    @(posedge ref_clk_i);
    fill_err_i <= 1'b0;
    rdchk(`PSR_OFF_STATUS, 32'h0);
    rdchk(`PSR_OFF_FILL_SYNDROME, 32'h0F0F);
    $display("test errors done");
endtask
// each trap kind with an invalidate and a scratch move in both window cycles
task automatic t_traps();
    // no memory op precedes the invalidates; exception address read late
    // no firmware returns, loads or stores are issued here
    mtw(5'd5, 64'hF0);
    for (int k = 0; k < 3; k++)
    begin
        @(posedge ref_clk_i);
        {trap_i, dxis_i, mtpr_scr_i} <= 3'b111;
        trap_src_i <= psr_trap_src_e'(k);
        trap_pc_i <= 32'h1000 + 32'(k);
        dxis_addr_i <= 32'hC000 + 32'(k);
        mtpr_idx_i <= 5'd5;
        mtpr_data_i <= 64'(k + 1);
        @(posedge ref_clk_i);
        trap_i <= 1'b0; // the moves repeat in cycle 1 of the window
        dxis_addr_i <= 32'hD000 + 32'(k);
        mtpr_data_i <= 64'h10 + 64'(k);
        @(negedge ref_clk_i);
        chk(64'(dxis_o), 64'(k != 2));
        chk(64'(exception_address_o), 64'h1000 + 64'(k));
        if (k != 2)
            chk(64'(dxis_addr_o), 64'hC000 + 64'(k));
        @(posedge ref_clk_i);
        {trap_i, dxis_i, mtpr_scr_i} <= 3'b000;
        @(negedge ref_clk_i);
        chk(64'(dxis_o), 64'(k != 2));
        if (k != 2)
            chk(64'(dxis_addr_o), 64'hD000 + 64'(k));
        mfr(5'd5, 64'h10);
    end
    rdchk(`PSR_OFF_EXCEPTION_ADDRESS, 32'h1002);
    $display("test traps done");
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence; the watchdog covers a hung handshake
initial
begin
    {ref_clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, fw_mode_i, rf_wr_en_i} = 7'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h0, 32'h0, 4'hF};
    {rf_wr_addr_i, rf_rd_addr_i, mtpr_idx_i, mfpr_idx_i} = 20'h0;
    {rf_wr_data_i, mtpr_data_i, mtpr_scr_i, mfpr_scr_i} = 130'h0;
    {dxis_i, dxis_addr_i, trap_i, trap_pc_i} = 66'h0;
    trap_src_i = PSR_TRAP_MBOX;
    {l2_err_i, ext_err_i, fill_err_i, fill_uncorr_i, fill_syndrome_i} = 20'h0;
    {l2_err_stat_i, l2_err_addr_i, ext_err_stat_i} = 96'h0;
    {ext_err_addr_i, board_cache_tag_address_i} = 64'h0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    t_shadow();
    t_scratch();
    t_errors();
    t_traps();
    conclude();
end
initial
begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    $display("Error at %0t: watchdog expired got %0h expected %0h", $time, 0, 1);
    conclude();
end
endmodule // test_psr_top
